// ==== rtl/bus_condition_detect.sv ====
`timescale 1ns/1ps

module bus_condition_detect (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_out,
   output logic start_out,
   output logic stop_out,
   output logic scl_rise_out,
   output logic scl_fall_out
);

   clkgen_ctrl_pkg::cond_t c;
   clkgen_ctrl_pkg::cond_t next_c;

   always_comb begin
      next_c = c;
      next_c.scl = scl_in;
      next_c.sda = sda_in;
      next_c.scl_d = c.scl;
      next_c.sda_d = c.sda;
   end

   // Idle bus is high, so reset to high avoids a false start
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         c <= 4'hF;
      end else begin
         c <= next_c;
      end
   end

   assign scl_out = c.scl;
   assign sda_out = c.sda;
   assign start_out = c.scl && c.scl_d && c.sda_d && !c.sda;
   assign stop_out = c.scl && c.scl_d && !c.sda_d && c.sda;
   assign scl_rise_out = c.scl && !c.scl_d;
   assign scl_fall_out = !c.scl && c.scl_d;

endmodule

// ==== rtl/clkgen_ctrl_consts.svh ====
`ifndef CLKGEN_CTRL_CONSTS_SVH
`define CLKGEN_CTRL_CONSTS_SVH

// ************************************************************
// Two-wire target addressing
// ************************************************************
`define CG_TARGET_ADDR 7'h69
`define CG_CMD_BYTE_MODE 7
`define CG_NUM_REGS 7'h06
`define CG_BLOCK_COUNT 8'h06
`define CG_LAST_BIT 4'h7
`define CG_BYTE_BITS 4'h8
`define CG_BYTE_NUM_MAX 3'h7

// ************************************************************
// Register offsets
// ************************************************************
`define CG_OFS_STRAP_SRC 7'h00
`define CG_OFS_MUX_SPREAD 7'h01

// ************************************************************
// Power-up values
// ************************************************************
`define CG_RST_STRAP_SRC 8'h01
`define CG_RST_MUX_SPREAD 8'h03
`define CG_RST_BUS_OE 8'hFF
`define CG_RST_UPPER_OE 8'hFF
`define CG_RST_LOWER_OE 8'hFF
`define CG_RST_CLK_REQ 8'h00

// ************************************************************
// Field positions
// ************************************************************
`define CG_B0_WMASK 8'h07
`define CG_B0_MODE 4
`define CG_B0_MAIN_SEL 2
`define CG_B0_STORAGE_SEL 1
`define CG_B0_KEEP 0
`define CG_B1_DOT_SEL 7
`define CG_B1_CFG_HI 4
`define CG_B1_CFG_LO 1
`define CG_B1_BUS_SEL 0
`define CG_B5_EN_02_A 7
`define CG_B5_SEL_02_A 6
`define CG_B5_EN_14_A 5
`define CG_B5_SEL_14_A 4
`define CG_B5_EN_02_B 3
`define CG_B5_SEL_02_B 2
`define CG_B5_EN_14_B 1
`define CG_B5_SEL_14_B 0

// ************************************************************
// Third synthesizer table codes
// ************************************************************
`define CG_CFG_OFF 4'h0
`define CG_CFG_100_SPREAD 4'h1
`define CG_CFG_RSVD_FIRST 4'hE

`endif

// ==== rtl/clkgen_ctrl_pkg.sv ====
package clkgen_ctrl_pkg;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RECV = 5'h02,
      ST_ACK = 5'h04,
      ST_SEND = 5'h08,
      ST_MACK = 5'h10
   } link_state_t;

   typedef logic [5:0][7:0] reg_bank_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic scl_d;
      logic sda_d;
   } cond_t;

   typedef struct packed {
      link_state_t state;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic [2:0] byte_num;
      logic rw;
      logic block;
      logic count_due;
      logic nack;
      logic [6:0] ptr;
      logic [2:0] straps;
      logic straps_taken;
      logic mode;
      reg_bank_t regs;
      logic sda_oe;
      logic [3:0] synth_c_cfg;
      logic synth_c_on;
      logic out1_from_main;
      logic [3:0] req_stop;
      logic [1:0] req_pin_input;
   } ctl_t;

endpackage

// ==== rtl/clock_gen_control_regs.sv ====

`timescale 1ns/1ps
`include "clkgen_ctrl_consts.svh"

module clock_gen_control_regs (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic freq_strap_a_in,
   input wire logic freq_strap_b_in,
   input wire logic freq_strap_c_in,
   input wire logic power_good_input_in,
   input wire logic test_mode_in,
   input wire logic powerdown_pin_in,
   input wire logic processor_stop_pin_in,
   input wire logic bus_stop_pin_in,
   input wire logic clk_req_0_2_n_in,
   input wire logic clk_req_1_4_n_in,
   output logic [2:0] freq_strap_out,
   output logic mgmt_engine_mode_out,
   output logic serial_ref_main_select_out,
   output logic storage_clk_select_out,
   output logic powerdown_keep_config_out,
   output logic out0_dot_select_out,
   output logic legacy_bus_clk_select_out,
   output logic [7:0] mux_and_spread_config_out,
   output logic [7:0] bus_clock_output_enables_out,
   output logic [7:0] upper_ref_output_enables_out,
   output logic [7:0] lower_ref_cpu_spread_enables_out,
   output logic [7:0] clock_request_pin_config_out,
   output logic [3:0] synth_c_freq_cfg_out,
   output logic synth_c_on_out,
   output logic out1_from_main_out,
   output logic [3:0] req_stop_out,
   output logic [1:0] req_pin_input_out
);

   // ************************************************************
   // Bus condition detection
   // ************************************************************
   logic scl_q;
   logic sda_q;
   logic ev_start;
   logic ev_stop;
   logic ev_rise;
   logic ev_fall;

   bus_condition_detect cond_u (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_out(scl_q),
      .sda_out(sda_q),
      .start_out(ev_start),
      .stop_out(ev_stop),
      .scl_rise_out(ev_rise),
      .scl_fall_out(ev_fall)
   );

   clkgen_ctrl_pkg::ctl_t s;
   clkgen_ctrl_pkg::ctl_t next_s;

   // ************************************************************
   // Read view of the bank
   // ************************************************************
   function automatic logic [7:0] read_reg(
      input clkgen_ctrl_pkg::reg_bank_t r,
      input logic [2:0] straps,
      input logic mode,
      input logic [6:0] idx
   );
      logic [7:0] v;

      // Offsets past the bank read as zero
      v = 8'h00;
      if (idx == `CG_OFS_STRAP_SRC) begin
         // Bit 3 is held at zero in storage
         v = r[0] & `CG_B0_WMASK;
         v[7:5] = straps;
         v[`CG_B0_MODE] = mode;
      end else if (idx < `CG_NUM_REGS) begin
         v = r[idx[2:0]];
      end
      return v;
   endfunction

   function automatic clkgen_ctrl_pkg::reg_bank_t default_bank();
      clkgen_ctrl_pkg::reg_bank_t r;

      r[0] = `CG_RST_STRAP_SRC;
      r[1] = `CG_RST_MUX_SPREAD;
      r[2] = `CG_RST_BUS_OE;
      r[3] = `CG_RST_UPPER_OE;
      r[4] = `CG_RST_LOWER_OE;
      r[5] = `CG_RST_CLK_REQ;
      return r;
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   logic [7:0] ld_data;
   logic table_applies;
   logic [3:0] cfg;
   logic [7:0] rq;
   logic req02;
   logic req14;

   always_comb begin
      next_s = s;
      ld_data = s.count_due ? `CG_BLOCK_COUNT
         : read_reg(s.regs, s.straps, s.mode, s.ptr);

      // One-shot capture; test mode reopens it
      if (power_good_input_in && (!s.straps_taken || test_mode_in)) begin
         next_s.straps = {freq_strap_c_in, freq_strap_b_in, freq_strap_a_in};
         next_s.straps_taken = 1'b1;
      end

      if (powerdown_pin_in && processor_stop_pin_in && bus_stop_pin_in) begin
         next_s.mode = 1'b1;
      end

      // Management mode is sticky, so it survives the clear
      if (powerdown_pin_in && !s.regs[0][`CG_B0_KEEP]) begin
         next_s.regs = default_bank();
      end

      if (ev_start) begin
         // Repeated start keeps pointer and access kind
         next_s.state = clkgen_ctrl_pkg::ST_RECV;
         next_s.bit_cnt = 4'h0;
         next_s.byte_num = 3'h0;
         next_s.sda_oe = 1'b0;
      end else if (ev_stop) begin
         next_s.state = clkgen_ctrl_pkg::ST_IDLE;
         next_s.sda_oe = 1'b0;
      end else begin
         case (s.state)
            clkgen_ctrl_pkg::ST_IDLE: begin
               next_s.sda_oe = 1'b0;
            end

            clkgen_ctrl_pkg::ST_RECV: begin
               if (ev_rise) begin
                  next_s.shift = {s.shift[6:0], sda_q};
                  next_s.bit_cnt = s.bit_cnt + 4'h1;
               end else if (ev_fall && s.bit_cnt == `CG_BYTE_BITS) begin
                  next_s.state = clkgen_ctrl_pkg::ST_ACK;
                  next_s.sda_oe = 1'b1;
                  // Saturating count; the pointer walks the bank
                  if (s.byte_num != `CG_BYTE_NUM_MAX) begin
                     next_s.byte_num = s.byte_num + 3'h1;
                  end
                  if (s.byte_num == 3'h0) begin
                     if (s.shift[7:1] == `CG_TARGET_ADDR) begin
                        next_s.rw = s.shift[0];
                        // Block read opens with the count byte
                        next_s.count_due = s.shift[0] && s.block;
                        next_s.nack = 1'b0;
                     end else begin
                        // Other targets: stay off the bus until next start
                        next_s.state = clkgen_ctrl_pkg::ST_IDLE;
                        next_s.sda_oe = 1'b0;
                     end
                  end else if (s.byte_num == 3'h1) begin
                     next_s.block = !s.shift[`CG_CMD_BYTE_MODE];
                     next_s.ptr = s.shift[`CG_CMD_BYTE_MODE] ? s.shift[6:0] : 7'h00;
                  end else if (!(s.block && s.byte_num == 3'h2)) begin
                     // Block byte count is accepted and not checked
                     next_s.ptr = s.ptr + 7'h01;
                     if (s.ptr == `CG_OFS_STRAP_SRC) begin
                        next_s.regs[0] = s.shift & `CG_B0_WMASK;
                        if (s.shift[`CG_B0_MODE]) begin
                           next_s.mode = 1'b1;
                        end
                     end else if (s.ptr < `CG_NUM_REGS) begin
                        next_s.regs[s.ptr[2:0]] = s.shift;
                     end
                  end
               end
            end

            clkgen_ctrl_pkg::ST_ACK: begin
               if (ev_fall) begin
                  next_s.bit_cnt = 4'h0;
                  if (s.rw) begin
                     next_s.state = clkgen_ctrl_pkg::ST_SEND;
                     next_s.shift = ld_data;
                     next_s.sda_oe = !ld_data[7];
                     next_s.count_due = 1'b0;
                     if (!s.count_due) begin
                        next_s.ptr = s.ptr + 7'h01;
                     end
                  end else begin
                     next_s.state = clkgen_ctrl_pkg::ST_RECV;
                     next_s.sda_oe = 1'b0;
                  end
               end
            end

            clkgen_ctrl_pkg::ST_SEND: begin
               if (ev_fall) begin
                  if (s.bit_cnt == `CG_LAST_BIT) begin
                     next_s.state = clkgen_ctrl_pkg::ST_MACK;
                     next_s.sda_oe = 1'b0;
                  end else begin
                     next_s.bit_cnt = s.bit_cnt + 4'h1;
                     next_s.shift = {s.shift[6:0], 1'b0};
                     // Open drain: enable drives a zero
                     next_s.sda_oe = !s.shift[6];
                  end
               end
            end

            clkgen_ctrl_pkg::ST_MACK: begin
               if (ev_rise) begin
                  next_s.nack = sda_q;
               end else if (ev_fall) begin
                  next_s.bit_cnt = 4'h0;
                  if (s.nack) begin
                     // Controller ended the read; wait for stop
                     next_s.state = clkgen_ctrl_pkg::ST_IDLE;
                  end else begin
                     next_s.state = clkgen_ctrl_pkg::ST_SEND;
                     next_s.shift = ld_data;
                     next_s.sda_oe = !ld_data[7];
                     next_s.count_due = 1'b0;
                     if (!s.count_due) begin
                        next_s.ptr = s.ptr + 7'h01;
                     end
                  end
               end
            end

            default: begin
               next_s.state = clkgen_ctrl_pkg::ST_IDLE;
               next_s.sda_oe = 1'b0;
            end
         endcase
      end

      // ************************************************************
      // Decoded controls, registered beside the bank
      // ************************************************************
      table_applies = !next_s.regs[0][`CG_B0_MAIN_SEL];
      cfg = next_s.regs[1][`CG_B1_CFG_HI:`CG_B1_CFG_LO];
      if (table_applies && cfg < `CG_CFG_RSVD_FIRST) begin
         next_s.synth_c_cfg = cfg;
         next_s.synth_c_on = (cfg != `CG_CFG_OFF);
         next_s.out1_from_main = (cfg == `CG_CFG_OFF) || (cfg == `CG_CFG_100_SPREAD);
      end else begin
         // Reserved codes park synth_c unless it is the main source
         next_s.synth_c_cfg = `CG_CFG_OFF;
         next_s.synth_c_on = !table_applies;
         next_s.out1_from_main = 1'b1;
      end

      rq = next_s.regs[5];
      req02 = !clk_req_0_2_n_in;
      req14 = !clk_req_1_4_n_in;
      next_s.req_pin_input[0] = rq[`CG_B5_EN_02_A] || rq[`CG_B5_EN_02_B];
      next_s.req_pin_input[1] = rq[`CG_B5_EN_14_A] || rq[`CG_B5_EN_14_B];
      // Stop flags ordered {out4, out2, out1, out0}
      next_s.req_stop[0] = req02 && ((rq[`CG_B5_EN_02_A] && !rq[`CG_B5_SEL_02_A])
         || (rq[`CG_B5_EN_02_B] && !rq[`CG_B5_SEL_02_B]));
      next_s.req_stop[2] = req02 && ((rq[`CG_B5_EN_02_A] && rq[`CG_B5_SEL_02_A])
         || (rq[`CG_B5_EN_02_B] && rq[`CG_B5_SEL_02_B]));
      next_s.req_stop[1] = req14 && ((rq[`CG_B5_EN_14_A] && !rq[`CG_B5_SEL_14_A])
         || (rq[`CG_B5_EN_14_B] && !rq[`CG_B5_SEL_14_B]));
      next_s.req_stop[3] = req14 && ((rq[`CG_B5_EN_14_A] && rq[`CG_B5_SEL_14_A])
         || (rq[`CG_B5_EN_14_B] && rq[`CG_B5_SEL_14_B]));
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         s <= '0;
         s.state <= clkgen_ctrl_pkg::ST_IDLE;
         s.regs <= default_bank();
         // Decoded controls match the default bank
         s.synth_c_cfg <= `CG_CFG_100_SPREAD;
         s.synth_c_on <= 1'b1;
         s.out1_from_main <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ************************************************************
   // Outputs, all but the constant sda_out taken from the state register
   // ************************************************************
   assign sda_out = 1'b0;
   assign sda_oe_out = s.sda_oe;
   assign freq_strap_out = s.straps;
   assign mgmt_engine_mode_out = s.mode;
   assign serial_ref_main_select_out = s.regs[0][`CG_B0_MAIN_SEL];
   assign storage_clk_select_out = s.regs[0][`CG_B0_STORAGE_SEL];
   assign powerdown_keep_config_out = s.regs[0][`CG_B0_KEEP];
   assign out0_dot_select_out = s.regs[1][`CG_B1_DOT_SEL];
   assign legacy_bus_clk_select_out = s.regs[1][`CG_B1_BUS_SEL];
   assign mux_and_spread_config_out = s.regs[1];
   assign bus_clock_output_enables_out = s.regs[2];
   assign upper_ref_output_enables_out = s.regs[3];
   assign lower_ref_cpu_spread_enables_out = s.regs[4];
   assign clock_request_pin_config_out = s.regs[5];
   assign synth_c_freq_cfg_out = s.synth_c_cfg;
   assign synth_c_on_out = s.synth_c_on;
   assign out1_from_main_out = s.out1_from_main;
   assign req_stop_out = s.req_stop;
   assign req_pin_input_out = s.req_pin_input;

endmodule

// ==== testbench/clkgen_ctrl_sva.sv ====
`timescale 1ns/1ps

module clkgen_ctrl_sva (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic scl_in,
   input wire logic sda_oe_out,
   input wire logic freq_strap_a_in,
   input wire logic freq_strap_b_in,
   input wire logic freq_strap_c_in,
   input wire logic power_good_input_in,
   input wire logic test_mode_in,
   input wire logic powerdown_pin_in,
   input wire logic processor_stop_pin_in,
   input wire logic bus_stop_pin_in,
   input wire logic clk_req_0_2_n_in,
   input wire logic [2:0] freq_strap_out,
   input wire logic mgmt_engine_mode_out,
   input wire logic serial_ref_main_select_out,
   input wire logic powerdown_keep_config_out,
   input wire logic [7:0] mux_and_spread_config_out,
   input wire logic [7:0] bus_clock_output_enables_out,
   input wire logic [7:0] clock_request_pin_config_out,
   input wire logic [3:0] synth_c_freq_cfg_out,
   input wire logic out1_from_main_out,
   input wire logic [3:0] req_stop_out,
   input wire logic [1:0] req_pin_input_out
);
   logic taken;

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         taken <= 1'b0;
      end else if (power_good_input_in) begin
         taken <= 1'b1;
      end
   end

   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   property p_strap_latch;
      (power_good_input_in && !taken) |=> freq_strap_out ==
         {$past(freq_strap_c_in), $past(freq_strap_b_in), $past(freq_strap_a_in)};
   endproperty
   property p_strap_hold;
      (taken && !test_mode_in) |=> $stable(freq_strap_out);
   endproperty
   property p_mode_sticky;
      mgmt_engine_mode_out |=> mgmt_engine_mode_out;
   endproperty
   property p_mode_pins;
      (powerdown_pin_in && processor_stop_pin_in && bus_stop_pin_in) |=> mgmt_engine_mode_out;
   endproperty
   property p_table;
      synth_c_freq_cfg_out == ((serial_ref_main_select_out ||
         mux_and_spread_config_out[4:1] >= 4'hE) ? 4'h0 : mux_and_spread_config_out[4:1]);
   endproperty
   property p_out1;
      (!serial_ref_main_select_out && mux_and_spread_config_out[4:1] <= 4'h1) |->
         out1_from_main_out;
   endproperty
   property p_req_role;
      req_pin_input_out == {clock_request_pin_config_out[5] | clock_request_pin_config_out[1],
                            clock_request_pin_config_out[7] | clock_request_pin_config_out[3]};
   endproperty
   property p_req_stop;
      (!clk_req_0_2_n_in && clock_request_pin_config_out[7:6] == 2'b10)[*2] |->
         ##[1:3] req_stop_out[0];
   endproperty
   property p_clear;
      (powerdown_pin_in && !powerdown_keep_config_out) |=> bus_clock_output_enables_out == 8'hFF;
   endproperty
   property p_sda_edge;
      ($rose(sda_oe_out) || $fell(sda_oe_out)) |-> !scl_in;
   endproperty

   a_strap_latch: assert property (p_strap_latch) else $error("strap latch wrong");
   a_strap_hold: assert property (p_strap_hold) else $error("straps moved");
   a_mode_sticky: assert property (p_mode_sticky) else $error("mode bit cleared");
   a_mode_pins: assert property (p_mode_pins) else $error("mode not set by pins");
   a_table: assert property (p_table) else $error("table code wrong");
   a_out1: assert property (p_out1) else $error("output 1 source wrong");
   a_req_role: assert property (p_req_role) else $error("request role wrong");
   a_req_stop: assert property (p_req_stop) else $error("request stop missing");
   a_clear: assert property (p_clear) else $error("config not cleared");
   a_sda_edge: assert property (p_sda_edge) else $error("data moved, clock high");

   c_req_stop: cover property (req_stop_out[0]);
   c_mode: cover property ($rose(mgmt_engine_mode_out));
   c_ack: cover property ($rose(sda_oe_out));
endmodule

bind clock_gen_control_regs clkgen_ctrl_sva chk (
   .core_clk_in(core_clk_in),
   .rst_in(rst_in),
   .scl_in(scl_in),
   .sda_oe_out(sda_oe_out),
   .freq_strap_a_in(freq_strap_a_in),
   .freq_strap_b_in(freq_strap_b_in),
   .freq_strap_c_in(freq_strap_c_in),
   .power_good_input_in(power_good_input_in),
   .test_mode_in(test_mode_in),
   .powerdown_pin_in(powerdown_pin_in),
   .processor_stop_pin_in(processor_stop_pin_in),
   .bus_stop_pin_in(bus_stop_pin_in),
   .clk_req_0_2_n_in(clk_req_0_2_n_in),
   .freq_strap_out(freq_strap_out),
   .mgmt_engine_mode_out(mgmt_engine_mode_out),
   .serial_ref_main_select_out(serial_ref_main_select_out),
   .powerdown_keep_config_out(powerdown_keep_config_out),
   .mux_and_spread_config_out(mux_and_spread_config_out),
   .bus_clock_output_enables_out(bus_clock_output_enables_out),
   .clock_request_pin_config_out(clock_request_pin_config_out),
   .synth_c_freq_cfg_out(synth_c_freq_cfg_out),
   .out1_from_main_out(out1_from_main_out),
   .req_stop_out(req_stop_out),
   .req_pin_input_out(req_pin_input_out)
);

// ==== testbench/clock_gen_control_regs_tb_top.sv ====
`timescale 1ns/1ps

module clock_gen_control_regs_tb_top;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic st_a = 1'b1, st_b = 1'b0, st_c = 1'b1;
   logic pg = 1'b0, pd = 1'b0, ps = 1'b0, bs = 1'b0, tm = 1'b0;
   logic rq02_n = 1'b1, rq14_n = 1'b1;
   logic dev_oe, m_scl, m_oe, sda;
   logic sel_main, sel_stor, keep, dot_sel, bus_sel, out1, c_on;
   logic [7:0] mux, oe2, oe3, oe4, req_cfg;
   logic [3:0] cfg_eff, req_stop;
   logic [1:0] req_in;
   logic [7:0] dflt [6] = '{8'hA1, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h00};
   logic [7:0] blk [6] = '{8'h01, 8'h5A, 8'h3C, 8'hA5, 8'h96, 8'hA0};
   logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h5, 4'hE};
   int errors = 0;
   int tests_run = 0;

   always #5 core_clk_in = ~core_clk_in;
   // Pulled-up data wire
   assign sda = ~(m_oe | dev_oe);

   smbus_ctrl_model m (.core_clk_in(core_clk_in), .sda_in(sda), .scl_out(m_scl),
                       .sda_oe_out(m_oe));

   clock_gen_control_regs uut (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .scl_in(m_scl), .sda_in(sda),
      .sda_out(), .sda_oe_out(dev_oe), .freq_strap_a_in(st_a), .freq_strap_b_in(st_b),
      .freq_strap_c_in(st_c), .power_good_input_in(pg), .test_mode_in(tm),
      .powerdown_pin_in(pd), .processor_stop_pin_in(ps), .bus_stop_pin_in(bs),
      .clk_req_0_2_n_in(rq02_n), .clk_req_1_4_n_in(rq14_n), .freq_strap_out(),
      .mgmt_engine_mode_out(), .serial_ref_main_select_out(sel_main),
      .storage_clk_select_out(sel_stor), .powerdown_keep_config_out(keep),
      .out0_dot_select_out(dot_sel), .legacy_bus_clk_select_out(bus_sel),
      .mux_and_spread_config_out(mux), .bus_clock_output_enables_out(oe2),
      .upper_ref_output_enables_out(oe3), .lower_ref_cpu_spread_enables_out(oe4),
      .clock_request_pin_config_out(req_cfg), .synth_c_freq_cfg_out(cfg_eff),
      .synth_c_on_out(c_on), .out1_from_main_out(out1), .req_stop_out(req_stop),
      .req_pin_input_out(req_in));

   // ************************************************************
   // Checking and bus tasks
   // ************************************************************
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic put(input logic [7:0] b, input logic want);
      logic [7:0] r;
      logic a;
      m.xfer(b, 1'b1, r, a);
      check("ack", {7'h00, a}, {7'h00, want});
   endtask

   task automatic head(input logic [7:0] cmd);
      m.cond(1'b0, 1'b1);
      put(8'hD2, 1'b1);
      put(cmd, 1'b1);
   endtask

   task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
      head({1'b1, ofs});
      put(d, 1'b1);
      m.cond(1'b1, 1'b0);
   endtask

   task automatic get(input string what, input logic [7:0] exp, input logic last);
      logic [7:0] r;
      logic a;
      m.xfer(8'hFF, last, r, a);
      check(what, r, exp);
   endtask

   task automatic rd(input logic [6:0] ofs, input logic [7:0] exp);
      head({1'b1, ofs});
      m.cond(1'b0, 1'b1);
      put(8'hD3, 1'b1);
      get("read data", exp, 1'b1);
      m.cond(1'b1, 1'b0);
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      wait_clk(16);
      rst_in <= 1'b0;
      wait_clk(4);
      pg <= 1'b1;
      wait_clk(2);
      st_a <= 1'b0;
      st_c <= 1'b0;
      for (int i = 0; i < 6; i++) rd(7'(i), dflt[i]);
      $display("Test power-up values done");
      pd <= 1'b1;
      ps <= 1'b1;
      bs <= 1'b1;
      wait_clk(1);
      pd <= 1'b0;
      ps <= 1'b0;
      bs <= 1'b0;
      rd(7'h00, 8'hB1);
      wr(7'h00, 8'hFF);
      rd(7'h00, 8'hB7);
      check("byte0 fields", {5'h00, sel_main, sel_stor, keep}, 8'h07);
      wr(7'h01, 8'h0A);
      check("ignored table", {4'h0, cfg_eff}, 8'h00);
      check("synth_c run", {7'h00, c_on}, 8'h01);
      wr(7'h00, 8'h01);
      for (int i = 0; i < 4; i++) begin
         wr(7'h01, {3'b101, codes[i], 1'b0});
         check("table", {4'h0, cfg_eff}, {4'h0, codes[i] >= 4'hE ? 4'h0 : codes[i]});
         check("synth_c run", {7'h00, c_on}, {7'h00, |codes[i] && codes[i] < 4'hE});
         check("mux fields", {6'h00, dot_sel, bus_sel}, 8'h02);
         check("mux raw", mux, {3'b101, codes[i], 1'b0});
         if (codes[i] <= 4'h1) check("out1 source", {7'h00, out1}, 8'h01);
      end
      $display("Test byte registers done");
      head(8'h00);
      put(8'h06, 1'b1);
      for (int i = 0; i < 6; i++) put(blk[i], 1'b1);
      m.cond(1'b1, 1'b0);
      head(8'h00);
      m.cond(1'b0, 1'b1);
      put(8'hD3, 1'b1);
      get("count", 8'h06, 1'b0);
      for (int i = 0; i < 6; i++) get("block", i == 0 ? 8'hB1 : blk[i], i == 5);
      m.cond(1'b1, 1'b0);
      check("bus enables", oe2, 8'h3C);
      check("upper enables", oe3, 8'hA5);
      check("lower enables", oe4, 8'h96);
      check("request roles", {6'h00, req_in}, 8'h03);
      $display("Test block access done");
      rq02_n <= 1'b0;
      wait_clk(4);
      check("request stop", {4'h0, req_stop}, 8'h01);
      rq02_n <= 1'b1;
      rq14_n <= 1'b0;
      wait_clk(4);
      check("request stop", {4'h0, req_stop}, 8'h02);
      wr(7'h05, 8'h0F);
      rq02_n <= 1'b0;
      wait_clk(4);
      check("request stop", {4'h0, req_stop}, 8'h0C);
      rq02_n <= 1'b1;
      rq14_n <= 1'b1;
      $display("Test clock requests done");
      wr(7'h07, 8'h55);
      rd(7'h07, 8'h00);
      m.cond(1'b0, 1'b1);
      put(8'hD4, 1'b0);
      m.cond(1'b1, 1'b0);
      wr(7'h00, 8'h00);
      rd(7'h00, 8'hB0);
      pd <= 1'b1;
      wait_clk(4);
      pd <= 1'b0;
      rd(7'h02, 8'hFF);
      tm <= 1'b1;
      wait_clk(2);
      tm <= 1'b0;
      rd(7'h00, 8'h11);
      $display("Test addressing and powerdown done");
      complete_run();
   end

   // Whole run is near 8000 cycles
   initial begin
      wait_clk(20000);
      errors++;
      complete_run();
   end
endmodule

// ==== testbench/smbus_ctrl_model.sv ====
`timescale 1ns/1ps

// ************************************************************
// Management controller on the two-wire link
// ************************************************************
module smbus_ctrl_model (
   input wire logic core_clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_out
);
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask

   // Start (0,1) or stop (1,0); clock goes low first
   task automatic cond(input logic d1, input logic d2);
      scl_out <= 1'b0;
      wt(2);
      sda_oe_out <= d1;
      wt(2);
      scl_out <= 1'b1;
      wt(4);
      sda_oe_out <= d2;
      wt(4);
   endtask

   // Phases of 4 cycles, above the 3-cycle minimum of the target
   task automatic bit1(input logic b, output logic r);
      scl_out <= 1'b0;
      wt(2);
      sda_oe_out <= ~b;
      wt(2);
      scl_out <= 1'b1;
      wt(2);
      r = sda_in;
      wt(2);
   endtask

   task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                       output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit1(tx[i], rx[i]);
      end
      bit1(mack, r);
      ack = ~r;
   endtask
endmodule
